//--- core/cantxq_top.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RQ1: queue_mode_select at 1 orders queue buffers by identifier, else FIFO.
// RQ2: queue mode sends pending queue messages lowest identifier first.
// RQ3: equal identifiers go out in ascending buffer number.
// RQ4: each add moves put_index cyclically to the next free buffer. An add of a buffer other than put_index leaves put_index in place.
// RQ5: all queue buffers pending sets queue_full_flag; put_index then invalid.
// RQ6: software writes no message while the queue is full.
// RQ7: software may fill any buffer without pending request; add accepts it. Add ignores buffers outside the dedicated and FIFO/queue sections.
// RQ8: each buffer occupies element size 32-bit words of message RAM.
// RQ9: next free address is start address plus put_index times element size.
// RQ10: mixed FIFO splits area into dedicated buffers then a FIFO section.
// RQ11: fifo_queue_size zero means dedicated buffers only.
// RQ12: FIFO mode arbitrates dedicated buffers plus oldest FIFO buffer by id.
// RQ13: mixed queue mode arbitrates dedicated plus queue buffers by id.
module cantxq_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire logic tx_done,
   output logic tx_req_valid,
   output logic [4:0] tx_req_index,
   output logic [15:0] tx_req_addr,
   output logic irq
);
   typedef struct packed {
      logic act;
      logic wr;
      logic [7:0] adr;
      logic [31:0] rdata;
      logic [13:0] bsa;
      logic [5:0] dedicated_buffer_count;
      logic [5:0] fifo_queue_size;
      logic qm;
      logic [4:0] elem;
      logic [31:0] pend;
      logic [4:0] put;
      logic [4:0] get;
      logic full;
      logic [2:0] istat;
      logic [2:0] imask;
      logic irq;
      logic sel_v;
      logic [4:0] sel;
      logic [15:0] sel_addr;
      logic [15:0] put_addr;
      logic [cantxq_pkg::NBUF-1:0][cantxq_pkg::ID_W-1:0] ids;
   } cantxq_state_s;

   cantxq_state_s q_ff, nxt_q;

   // buffers lo..lo+n-1, clipped at the last buffer
   function automatic logic [31:0] span(input logic [5:0] lo,
                                        input logic [5:0] n);
      logic [6:0] hi;
      hi = 7'(lo) + 7'(n);
      for (int i = 0; i < cantxq_pkg::NBUF; i++) begin
         span[i] = (7'(i) >= 7'(lo)) && (7'(i) < hi);
      end
   endfunction

   // cyclic search in a section for a buffer whose pending bit equals want
   function automatic logic [5:0] seek(input logic [31:0] pv,
                                       input logic [4:0] start,
                                       input logic [5:0] base,
                                       input logic [5:0] n,
                                       input logic want);
      logic [6:0] rel0;
      logic [6:0] rel;
      logic [6:0] idx;
      seek = 6'h00;
      rel0 = 7'(start) - 7'(base);
      if (7'(start) < 7'(base) || rel0 >= 7'(n)) begin
         rel0 = 7'h00;
      end
      for (int k = cantxq_pkg::NBUF - 1; k >= 0; k--) begin
         rel = rel0 + 7'(k);
         if (rel >= 7'(n)) begin
            rel = rel - 7'(n);
         end
         idx = 7'(base) + rel;
         if (7'(k) < 7'(n) && idx < 7'h20 && pv[idx[4:0]] == want) begin
            seek = {1'b1, idx[4:0]};
         end
      end
   endfunction

   function automatic logic [15:0] buf_addr(input logic [13:0] bsa,
                                            input logic [4:0] idx,
                                            input logic [4:0] elem);
      // all terms at 16 bits so the product cannot lose its upper bits
      buf_addr = {bsa, 2'h0} + 16'(idx) * 16'(elem) * 16'h0004; // RQ8 RQ9
   endfunction

   always_comb begin
      logic [31:0] ded;
      logic [31:0] sec;
      logic [31:0] elig;
      logic [31:0] addv;
      logic [31:0] canv;
      logic [5:0] fnd;
      logic [cantxq_pkg::ID_W-1:0] best;
      logic [31:0] rd;
      logic [7:0] ra;
      logic [2:0] ev;
      ded = 32'h0000_0000;
      sec = 32'h0000_0000;
      elig = 32'h0000_0000;
      addv = 32'h0000_0000;
      canv = 32'h0000_0000;
      fnd = 6'h00;
      best = '1;
      rd = 32'h0000_0000;
      ra = haddr[7:0];
      ev = 3'h0;
      nxt_q = q_ff;

      // data phase of a write
      if (q_ff.act && q_ff.wr) begin
         if (q_ff.adr[7]) begin
            nxt_q.ids[q_ff.adr[6:2]] = hwdata[cantxq_pkg::ID_W-1:0];
         end else begin
            case (q_ff.adr)
               cantxq_pkg::OFS_CONFIG: begin
                  nxt_q.bsa = hwdata[cantxq_pkg::CFG_BSA_MSB:
                                     cantxq_pkg::CFG_BSA_LSB];
                  nxt_q.dedicated_buffer_count = hwdata[cantxq_pkg::CFG_DEDICATED_BUFFER_COUNT_LSB+:6];
                  nxt_q.fifo_queue_size = hwdata[cantxq_pkg::CFG_FIFO_QUEUE_SIZE_LSB+:6];
                  nxt_q.qm = hwdata[cantxq_pkg::CFG_QM_BIT]; // RQ1
               end
               cantxq_pkg::OFS_ELEM: nxt_q.elem = hwdata[4:0];
               cantxq_pkg::OFS_ADD: addv = hwdata;
               cantxq_pkg::OFS_CANCEL: canv = hwdata;
               cantxq_pkg::OFS_IMASK: nxt_q.imask = hwdata[2:0];
               default: ;
            endcase
         end
      end

      // sections from the current configuration
      ded = span(6'h00, q_ff.dedicated_buffer_count); // RQ10
      sec = span(q_ff.dedicated_buffer_count, q_ff.fifo_queue_size); // RQ10 RQ11 RQ13

      // clears first, then adds, so a re-add in the done cycle survives
      if (tx_done && q_ff.sel_v) begin
         nxt_q.pend[q_ff.sel] = 1'b0;
         ev[cantxq_pkg::EV_DONE] = 1'b1;
      end
      if ((canv & q_ff.pend) != 32'h0000_0000) begin
         ev[cantxq_pkg::EV_CANCEL] = 1'b1;
      end
      nxt_q.pend = nxt_q.pend & ~canv;
      // any configured buffer may be added, not only the put one
      nxt_q.pend = nxt_q.pend | (addv & (ded | sec)); // RQ7

      // put index: next free buffer of the section, cyclic
      fnd = seek(nxt_q.pend, q_ff.put, q_ff.dedicated_buffer_count, q_ff.fifo_queue_size, 1'b0); // RQ4
      if (fnd[5]) begin
         nxt_q.put = fnd[4:0];
      end
      nxt_q.full = (q_ff.fifo_queue_size != 6'h00) && fnd[5] == 1'b0; // RQ5 RQ11
      if (nxt_q.full && !q_ff.full) begin
         ev[cantxq_pkg::EV_FULL] = 1'b1;
      end
      nxt_q.put_addr = buf_addr(q_ff.bsa, nxt_q.put, q_ff.elem); // RQ9

      // oldest pending FIFO buffer
      fnd = seek(nxt_q.pend, q_ff.get, q_ff.dedicated_buffer_count, q_ff.fifo_queue_size, 1'b1);
      if (fnd[5]) begin
         nxt_q.get = fnd[4:0];
      end

      // eligible set
      elig = nxt_q.pend & ded;
      if (q_ff.qm) begin
         elig = elig | (nxt_q.pend & sec); // RQ1 RQ13
      end else if (fnd[5]) begin
         elig[fnd[4:0]] = 1'b1; // RQ12
      end

      // strict compare: the lower buffer number keeps a tie
      nxt_q.sel_v = 1'b0;
      for (int i = 0; i < cantxq_pkg::NBUF; i++) begin
         if (elig[i] && (!nxt_q.sel_v || nxt_q.ids[i] < best)) begin
            nxt_q.sel_v = 1'b1; // RQ2 RQ12
            nxt_q.sel = 5'(i); // RQ3
            best = nxt_q.ids[i];
         end
      end
      nxt_q.sel_addr = buf_addr(q_ff.bsa, nxt_q.sel, q_ff.elem);

      // interrupts: set wins over write-one-to-clear
      if (q_ff.act && q_ff.wr && q_ff.adr == cantxq_pkg::OFS_ISTAT) begin
         nxt_q.istat = q_ff.istat & ~hwdata[2:0];
      end
      nxt_q.istat = nxt_q.istat | ev;
      nxt_q.irq = |(nxt_q.istat & nxt_q.imask);

      // address phase; read data reflect state before this cycle's write
      nxt_q.act = hsel && hready && htrans == cantxq_pkg::HTRANS_NONSEQ;
      if (hsel && hready) begin
         nxt_q.wr = hwrite;
         nxt_q.adr = {ra[7:2], 2'h0};
      end
      if (ra[7]) begin
         rd = 32'(q_ff.ids[ra[6:2]]);
      end else begin
         case ({ra[7:2], 2'h0})
            cantxq_pkg::OFS_CONFIG: rd = {1'b0, q_ff.qm, q_ff.fifo_queue_size,
                                          2'h0, q_ff.dedicated_buffer_count, q_ff.bsa, 2'h0};
            cantxq_pkg::OFS_ELEM: rd = 32'(q_ff.elem);
            cantxq_pkg::OFS_STATUS: rd = {15'h0000, q_ff.full,
                                          3'h0, q_ff.put, 3'h0, q_ff.get};
            cantxq_pkg::OFS_PEND: rd = q_ff.pend;
            cantxq_pkg::OFS_PUTADDR: rd = 32'(q_ff.put_addr);
            cantxq_pkg::OFS_SEL: rd = {q_ff.sel_v, 10'h000, q_ff.sel,
                                       q_ff.sel_addr};
            cantxq_pkg::OFS_ISTAT: rd = 32'(q_ff.istat);
            cantxq_pkg::OFS_IMASK: rd = 32'(q_ff.imask);
            default: rd = 32'h0000_0000;
         endcase
      end
      if (nxt_q.act && !hwrite) begin
         nxt_q.rdata = rd;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q_ff <= '0;
         q_ff.bsa <= cantxq_pkg::RST_BSA;
         q_ff.dedicated_buffer_count <= cantxq_pkg::RST_DEDICATED_BUFFER_COUNT;
         q_ff.fifo_queue_size <= cantxq_pkg::RST_FIFO_QUEUE_SIZE;
         q_ff.elem <= cantxq_pkg::RST_ELEM;
         q_ff.rdata <= cantxq_pkg::RST_WORD;
         q_ff.istat <= cantxq_pkg::RST_IRQ;
         q_ff.imask <= cantxq_pkg::RST_IRQ;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = q_ff.rdata;
   assign tx_req_valid = q_ff.sel_v;
   assign tx_req_index = q_ff.sel;
   assign tx_req_addr = q_ff.sel_addr;
   assign irq = q_ff.irq;

   sequence s_add_wr;
      q_ff.act && q_ff.wr && q_ff.adr == cantxq_pkg::OFS_ADD;
   endsequence

   sequence s_sent;
      tx_done && q_ff.sel_v;
   endsequence

   a_irq_level: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
      irq == |(q_ff.istat & q_ff.imask))
      else $error("irq does not follow masked status");
   a_full_flag: assert property (@(posedge hclk) disable iff (!hresetn) // RQ5
      q_ff.full == (q_ff.fifo_queue_size != 6'h00 &&
         (~q_ff.pend & span(q_ff.dedicated_buffer_count, q_ff.fifo_queue_size)) == 32'h0000_0000 &&
         $stable(q_ff.dedicated_buffer_count) && $stable(q_ff.fifo_queue_size)) || $changed(q_ff.fifo_queue_size)
         || $changed(q_ff.dedicated_buffer_count))
      else $error("queue full flag wrong");
   a_put_free: assert property (@(posedge hclk) disable iff (!hresetn) // RQ4
      !q_ff.full && q_ff.fifo_queue_size != 6'h00 && $stable(q_ff.fifo_queue_size)
         && $stable(q_ff.dedicated_buffer_count) |-> !q_ff.pend[q_ff.put])
      else $error("put index points at a pending buffer");
   a_sel_pend: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
      tx_req_valid |-> q_ff.pend[tx_req_index])
      else $error("selected buffer not pending");
   a_sent_clear: assert property (@(posedge hclk) disable iff (!hresetn) // RQ2
      s_sent ##0 !(q_ff.act && q_ff.wr) |=> !q_ff.pend[$past(q_ff.sel)])
      else $error("sent buffer still pending");
   a_addr_calc: assert property (@(posedge hclk) disable iff (!hresetn) // RQ9
      $stable(q_ff.bsa) && $stable(q_ff.elem) |->
         q_ff.put_addr == 16'({q_ff.bsa, 2'h0} + q_ff.put * q_ff.elem * 4))
      else $error("put address wrong");
   a_rsp_okay: assert property (@(posedge hclk) disable iff (!hresetn)
      hreadyout && !hresp)
      else $error("bus response not OKAY");
   a_ded_only: assert property (@(posedge hclk) disable iff (!hresetn) // RQ11
      q_ff.fifo_queue_size == 6'h00 && !q_ff.qm |-> !q_ff.full &&
         (!tx_req_valid || {1'b0, tx_req_index} < q_ff.dedicated_buffer_count))
      else $error("non-dedicated buffer used without a section");
   a_add_sets: assert property (@(posedge hclk) disable iff (!hresetn) // RQ7
      s_add_wr ##0 (hwdata[0] && (q_ff.dedicated_buffer_count != 6'h00 || q_ff.fifo_queue_size != 6'h00))
         ##0 !tx_done |=> q_ff.pend[0])
      else $error("add request not taken");
endmodule
`default_nettype wire

//--- core/cantxq_pkg.sv
package cantxq_pkg;
   localparam int NBUF = 32;
   localparam int ID_W = 29;
   // register byte offsets
   localparam logic [7:0] OFS_CONFIG = 8'h00;
   localparam logic [7:0] OFS_ELEM = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_PEND = 8'h0c;
   localparam logic [7:0] OFS_ADD = 8'h10;
   localparam logic [7:0] OFS_CANCEL = 8'h14;
   localparam logic [7:0] OFS_PUTADDR = 8'h18;
   localparam logic [7:0] OFS_SEL = 8'h1c;
   localparam logic [7:0] OFS_ISTAT = 8'h20;
   localparam logic [7:0] OFS_IMASK = 8'h24;
   localparam logic [7:0] OFS_ID_BASE = 8'h80;
   // tx_buffer_config fields
   localparam int CFG_BSA_LSB = 2;
   localparam int CFG_BSA_MSB = 15;
   localparam int CFG_DEDICATED_BUFFER_COUNT_LSB = 16;
   localparam int CFG_FIFO_QUEUE_SIZE_LSB = 24;
   localparam int CFG_QM_BIT = 30;
   // fifo_queue_status fields
   localparam int STS_GET_LSB = 0;
   localparam int STS_PUT_LSB = 8;
   localparam int STS_FULL_BIT = 16;
   // interrupt bits
   localparam int EV_DONE = 0;
   localparam int EV_FULL = 1;
   localparam int EV_CANCEL = 2;
   // reset values
   localparam logic [13:0] RST_BSA = 14'h0000;
   localparam logic [5:0] RST_DEDICATED_BUFFER_COUNT = 6'h00;
   localparam logic [5:0] RST_FIFO_QUEUE_SIZE = 6'h00;
   localparam logic [4:0] RST_ELEM = 5'h04;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [2:0] RST_IRQ = 3'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- test/cantxq_engine_model.sv
`timescale 1ns/10ps
`default_nettype none
module cantxq_engine_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic tx_req_valid,
   input wire logic go,
   input wire logic [3:0] lag,
   output logic tx_done
);
   logic [3:0] cnt_ff;
   // one pulse per selection, never two in a row; the block retires the
   // buffer and shows its next choice at the same clock edge
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_ff <= 4'h0;
         tx_done <= 1'b0;
      end else if (tx_done || !go || !tx_req_valid) begin
         cnt_ff <= 4'h0;
         tx_done <= 1'b0;
      end else if (cnt_ff >= lag) begin
         tx_done <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 4'h1;
      end
   end
endmodule
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, go;
   logic tx_done, tx_req_valid, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] lag;
   logic [4:0] tx_req_index;
   logic [15:0] tx_req_addr;
   int failures, num_checks, cycles;
   assign hready = hreadyout;
   cantxq_top i_cantxq_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .tx_done(tx_done),
      .tx_req_valid(tx_req_valid), .tx_req_index(tx_req_index),
      .tx_req_addr(tx_req_addr), .irq(irq));
   cantxq_engine_model i_cantxq_engine_model (.hclk(hclk),
      .hresetn(hresetn), .tx_req_valid(tx_req_valid), .go(go), .lag(lag),
      .tx_done(tx_done));
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   task automatic wrap_up;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // ceiling well above the few hundred cycles the scenarios need
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      hsel <= 1'b1;
      htrans <= cantxq_pkg::HTRANS_NONSEQ;
      hwrite <= w;
      haddr <= {24'h000000, a};
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
      hsel <= 1'b0;
      // idle gap so a following read sees the written state
      @(posedge hclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdm(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q & m, e);
   endtask
   task automatic do_reset;
      hresetn <= 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
   endtask
   task automatic setup(input logic [5:0] nd, input logic [5:0] qs,
                        input logic qm);
      do_reset();
      wr(cantxq_pkg::OFS_ELEM, 32'h00000012);
      wr(cantxq_pkg::OFS_CONFIG, {1'b0, qm, qs, 2'h0, nd, 14'h0040, 2'h0});
   endtask
   task automatic ids4(input logic [31:0] a, b, c, d);
      wr(8'h80, a);
      wr(8'h84, b);
      wr(8'h88, c);
      wr(8'h8c, d);
   endtask
   task automatic see_tx(input logic [4:0] e);
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (tx_done !== 1'b1 && n < 100);
      // a send that never comes counts as a mismatch
      chk({31'h0, tx_done}, 32'h1);
      chk({27'h0, tx_req_index}, {27'h0, e});
      chk({16'h0, tx_req_addr}, 32'h00000100 + e * 32'h48);
   endtask
   task automatic t_reset;
      rdm(cantxq_pkg::OFS_ELEM, 32'hffffffff, 32'h00000004);
      rdm(cantxq_pkg::OFS_PEND, 32'hffffffff, 32'h00000000);
      rdm(cantxq_pkg::OFS_CONFIG, 32'hffffffff, 32'h00000000);
      rdm(cantxq_pkg::OFS_ISTAT, 32'hffffffff, 32'h00000000);
      chk({31'h0, irq | hresp | tx_req_valid}, 32'h0);
   endtask
   task automatic t_queue;
      setup(6'h00, 6'h04, 1'b1);
      ids4(32'h5, 32'h3, 32'h3, 32'h9);
      wr(cantxq_pkg::OFS_IMASK, 32'h00000001);
      wr(cantxq_pkg::OFS_ADD, 32'h0000000f);
      rdm(cantxq_pkg::OFS_STATUS, 32'h00010000, 32'h00010000);
      chk({31'h0, irq}, 32'h0);
      lag <= 4'h0;
      go <= 1'b1;
      see_tx(5'h01);
      see_tx(5'h02);
      see_tx(5'h00);
      see_tx(5'h03);
      go <= 1'b0;
      repeat (2) @(posedge hclk);
      chk({31'h0, irq}, 32'h1);
      rdm(cantxq_pkg::OFS_ISTAT, 32'h00000007, 32'h00000003);
      wr(cantxq_pkg::OFS_ISTAT, 32'h00000007);
      chk({31'h0, irq}, 32'h0);
   endtask
   task automatic t_put;
      setup(6'h00, 6'h04, 1'b1);
      rdm(cantxq_pkg::OFS_STATUS, 32'h00011f00, 32'h00000000);
      wr(cantxq_pkg::OFS_ADD, 32'h00000001);
      rdm(cantxq_pkg::OFS_STATUS, 32'h00011f00, 32'h00000100);
      wr(cantxq_pkg::OFS_ADD, 32'h00000004);
      rdm(cantxq_pkg::OFS_PEND, 32'hffffffff, 32'h00000005);
      wr(cantxq_pkg::OFS_ADD, 32'h00000002);
      rdm(cantxq_pkg::OFS_STATUS, 32'h00011f00, 32'h00000300);
      rdm(cantxq_pkg::OFS_PUTADDR, 32'hffffffff, 32'h000001d8);
      wr(cantxq_pkg::OFS_ADD, 32'h00000008);
      rdm(cantxq_pkg::OFS_STATUS, 32'h00010000, 32'h00010000);
      // software backs off while full and frees a slot by cancelling
      wr(cantxq_pkg::OFS_CANCEL, 32'h00000004);
      rdm(cantxq_pkg::OFS_PEND, 32'hffffffff, 32'h0000000b);
      rdm(cantxq_pkg::OFS_STATUS, 32'h00011f00, 32'h00000200);
      rdm(cantxq_pkg::OFS_ISTAT, 32'h00000007, 32'h00000006);
      chk({31'h0, irq}, 32'h0);
   endtask
   task automatic t_fifo;
      setup(6'h02, 6'h02, 1'b0);
      ids4(32'd20, 32'd30, 32'd10, 32'd1);
      wr(cantxq_pkg::OFS_ADD, 32'h00000004);
      wr(cantxq_pkg::OFS_ADD, 32'h00000008);
      wr(cantxq_pkg::OFS_ADD, 32'h00000003);
      lag <= 4'h3;
      go <= 1'b1;
      see_tx(5'h02);
      see_tx(5'h03);
      see_tx(5'h00);
      see_tx(5'h01);
      go <= 1'b0;
   endtask
   task automatic t_mixq;
      setup(6'h01, 6'h02, 1'b1);
      ids4(32'd7, 32'd2, 32'd4, 32'd0);
      wr(cantxq_pkg::OFS_ADD, 32'h00000007);
      lag <= 4'h0;
      go <= 1'b1;
      see_tx(5'h01);
      see_tx(5'h02);
      see_tx(5'h00);
      go <= 1'b0;
      wr(cantxq_pkg::OFS_CONFIG, {10'h0, 6'h02, 14'h0040, 2'h0});
      wr(cantxq_pkg::OFS_ADD, 32'h0000000f);
      rdm(cantxq_pkg::OFS_PEND, 32'hffffffff, 32'h00000003);
   endtask
   initial begin
      failures = 0;
      num_checks = 0;
      cycles = 0;
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      go = 1'b0;
      lag = 4'h0;
      do_reset();
      t_reset();
      t_queue();
      t_put();
      t_fifo();
      t_mixq();
      wrap_up();
   end
endmodule
`default_nettype wire
